// ===== pcr_map.svh
// Register offsets, word fields, reset values and timing counts
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PCR_OFS_WORD 8'h00
`define PCR_OFS_CTRL 8'h04
`define PCR_OFS_STAT 8'h08

// ****************************************
// Serial word fields
// ****************************************
`define PCR_SEL_LSB 0
`define PCR_SEL_MSB 3
`define PCR_SEL_PDWORD 4'hD
`define PCR_SEL_CTWORD 4'hF
`define PCR_CSR_LSB 22
`define PCR_CSR_MSB 23
`define PCR_BIT_PREDIV 4
`define PCR_BIT_AUX_CLR 5
`define PCR_BIT_MAIN_CLR 6
`define PCR_BIT_MAIN_FLT 7
`define PCR_BIT_AUX_FLT 8
`define PCR_WORD_W 24

// ****************************************
// Control and status fields
// ****************************************
`define PCR_CTRL_SOFT_PD 0
`define PCR_CTRL_RST 1'h0
`define PCR_RESP_OKAY 2'h0
`define PCR_RESP_SLVERR 2'h2

// ****************************************
// Timing
// ****************************************
`define PCR_CLK_MHZ 100
`define PCR_PWRUP_NS 1000
`define PCR_PWRUP_CYC ((`PCR_PWRUP_NS * `PCR_CLK_MHZ + 999) / 1000)

`endif

// ===== pcr_pkg.sv
// Types shared by the counter reset and pump float control block
`default_nettype none

package pcr_pkg;

    typedef logic [7:0] pcr_addr_t;
    typedef logic [31:0] pcr_data_t;

    typedef struct packed {
        logic prev_on;
        logic [15:0] cnt;
        logic hold;
    } pcr_pwrup_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } pcr_div_s;

    typedef struct packed {
        logic aw_full;
        pcr_addr_t aw_addr;
        logic w_full;
        pcr_data_t wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        pcr_data_t rdata;
        logic [23:0] last_word;
        logic [1:0] csr_sel;
        logic prediv;
        logic main_clear;
        logic aux_clear;
        logic main_float;
        logic aux_float;
        logic soft_pd;
        logic main_rst;
        logic aux_rst;
        logic main_hiz;
        logic aux_hiz;
    } pcr_top_s;

endpackage

`default_nettype wire

// ===== pcr_tick_div.sv
// Programmable divider of a one-cycle tick stream
`timescale 1ns/1ps
`default_nettype none

module pcr_tick_div
    import pcr_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic clear, // Hold count at zero
    input wire logic [W-1:0] ratio_m1, // Divide ratio minus one
    input wire logic tick_in, // Input tick
    output logic tick_out // Divided tick
);

    if (W < 1 || W > 16) begin : g_bad_w
        $error("pcr_tick_div: W must be 1 to 16");
    end

    pcr_div_s q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (clear) begin
            d.cnt = '0;
        end else if (tick_in) begin
            if (q.cnt[W-1:0] >= ratio_m1) begin
                d.cnt = '0;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.tick;

endmodule

`default_nettype wire

// ===== pcr_pwrup.sv
// Counter reset hold on every power-up
`timescale 1ns/1ps
`default_nettype none
`include "pcr_map.svh"

module pcr_pwrup
    import pcr_pkg::*;
#(
    parameter int CYCLES = `PCR_PWRUP_CYC
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic powered, // Chip powered level
    output logic hold // Counter reset hold
);

    if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cyc
        $error("pcr_pwrup: CYCLES must be 1 to 65535");
    end

    localparam logic [15:0] LOAD = 16'(CYCLES - 1);

    pcr_pwrup_s q, d;

    always_comb begin
        d = q;
        d.prev_on = powered;
        if (!powered) begin
            d.cnt = '0;
            d.hold = 1'b1;
        end else if (!q.prev_on) begin
            d.cnt = LOAD;
            d.hold = 1'b1;
        end else if (q.cnt != 16'h0000) begin
            d.cnt = q.cnt - 16'h0001;
            d.hold = 1'b1;
        end else begin
            d.hold = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '{prev_on: 1'b0, cnt: 16'h0000, hold: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign hold = q.hold;

endmodule

`default_nettype wire

// ===== pcr_ctrl.sv
// Control word decode for both synthesizer loops, AXI4-Lite slave
// Function
// [R1] Selector 0..3 gives rate 1, 1/2, 1/4, 1/16
// [R2] Divide option quarters main lock-detect rate
// [R3] Auxiliary lock-detect rate never divided
// [R4] Host sets divide above 20 MHz
// [R5] Auxiliary clear: counters reset, pump floats
// [R6] Main clear: counters reset, pump floats
// [R7] Counter reset applied on every power-up
// [R8] Main float: pump floats, counters run
// [R9] Auxiliary float: pump floats, counters run
// [R10] Host keeps clear bits zero normally
// [R11] Float on clear or float; reset on clear
// [R12] Control bits latch only from select 1111
`timescale 1ns/1ps
`default_nettype none
`include "pcr_map.svh"

module pcr_ctrl
    import pcr_pkg::*;
#(
    parameter int PWRUP_CYCLES = `PCR_PWRUP_CYC
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic chip_enable, // Chip enable pin level
    input wire logic main_cmp_tick, // Main comparison tick
    input wire logic aux_cmp_tick, // Auxiliary comparison tick
    output logic csr_sample_tick, // Reduced main sample tick
    output logic csr_active, // Slip reduction enabled
    output logic main_ld_tick, // Main lock-detect tick
    output logic aux_ld_tick, // Auxiliary lock-detect tick
    output logic main_counter_reset, // Main N and R reset
    output logic aux_counter_reset, // Aux N and R reset
    output logic main_pump_hiz, // Main pump floated
    output logic aux_pump_hiz // Aux pump floated
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic [3:0] csr_ratio_m1(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        unique case (sel)
            2'h0: r = 4'h0;
            2'h1: r = 4'h1;
            2'h2: r = 4'h3;
            2'h3: r = 4'hF;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] strb_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] v;
        v = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // ****************************************
    // State
    // ****************************************
    pcr_top_s q, d;

    logic powered;
    logic pwr_hold;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [3:0] csr_m1;
    logic [1:0] ld_m1;
    logic wr_go;
    logic rd_go;
    logic [23:0] wword;
    logic [31:0] ctrl_wr;

    assign powered = chip_enable & ~q.soft_pd;
    assign csr_m1 = csr_ratio_m1(q.csr_sel); // R1
    assign ld_m1 = q.prediv ? 2'h3 : 2'h0; // R2
    assign wr_go = q.aw_full & q.w_full & ~q.bvalid;
    assign rd_go = s_axi_arvalid & ~q.rvalid;
    assign wword = q.wdata[`PCR_WORD_W-1:0];
    assign ctrl_wr = strb_merge(ctrl_word, q.wdata, q.wstrb);

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`PCR_CTRL_SOFT_PD] = q.soft_pd;
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[1:0] = q.csr_sel;
        stat_word[2] = q.prediv;
        stat_word[3] = q.main_clear;
        stat_word[4] = q.aux_clear;
        stat_word[5] = q.main_float;
        stat_word[6] = q.aux_float;
        stat_word[7] = q.main_rst;
        stat_word[8] = q.aux_rst;
        stat_word[9] = q.main_hiz;
        stat_word[10] = q.aux_hiz;
        stat_word[11] = powered;
        stat_word[12] = pwr_hold;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;

        // Address and data channels taken in either order
        if (s_axi_awvalid && !q.aw_full) begin
            d.aw_full = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_full) begin
            d.w_full = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end

        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        if (wr_go) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `PCR_RESP_OKAY;
            unique case (q.aw_addr)
                `PCR_OFS_WORD: begin
                    // Whole word only; partial writes refused
                    if (q.wstrb[2:0] != 3'h7) begin
                        d.bresp = `PCR_RESP_SLVERR;
                    end else begin
                        d.last_word = wword;
                        if (wword[`PCR_SEL_MSB:`PCR_SEL_LSB]
                            == `PCR_SEL_PDWORD) begin
                            d.csr_sel = wword[`PCR_CSR_MSB:`PCR_CSR_LSB];
                        end
                        if (wword[`PCR_SEL_MSB:`PCR_SEL_LSB]
                            == `PCR_SEL_CTWORD) begin // R12
                            d.prediv = wword[`PCR_BIT_PREDIV];
                            d.aux_clear = wword[`PCR_BIT_AUX_CLR];
                            d.main_clear = wword[`PCR_BIT_MAIN_CLR];
                            d.main_float = wword[`PCR_BIT_MAIN_FLT];
                            d.aux_float = wword[`PCR_BIT_AUX_FLT];
                        end
                    end
                end
                `PCR_OFS_CTRL: begin
                    d.soft_pd = ctrl_wr[`PCR_CTRL_SOFT_PD];
                end
                `PCR_OFS_STAT: begin
                    d.bresp = `PCR_RESP_SLVERR;
                end
                default: begin
                    d.bresp = `PCR_RESP_SLVERR;
                end
            endcase
        end

        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp = `PCR_RESP_OKAY;
            unique case (s_axi_araddr)
                `PCR_OFS_WORD: d.rdata = {8'h00, q.last_word};
                `PCR_OFS_CTRL: d.rdata = ctrl_word;
                `PCR_OFS_STAT: d.rdata = stat_word;
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = `PCR_RESP_SLVERR;
                end
            endcase
        end

        // Loop outputs: power-up hold also resets and floats both loops
        d.main_rst = q.main_clear | pwr_hold; // R6 R7 R11
        d.aux_rst = q.aux_clear | pwr_hold; // R5 R7 R11
        d.main_hiz = q.main_clear | q.main_float | pwr_hold; // R6 R8 R11
        d.aux_hiz = q.aux_clear | q.aux_float | pwr_hold; // R5 R9 R11
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.soft_pd <= `PCR_CTRL_RST;
            q.main_rst <= 1'b1;
            q.aux_rst <= 1'b1;
            q.main_hiz <= 1'b1;
            q.aux_hiz <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Power-up counter reset
    // ****************************************
    pcr_pwrup #(
        .CYCLES(PWRUP_CYCLES)
    ) u_pwrup (
        .clk(clk),
        .reset(reset),
        .powered(powered), // R7
        .hold(pwr_hold)
    );

    // ****************************************
    // Rate dividers
    // ****************************************
    pcr_tick_div #(
        .W(4)
    ) u_csr_div (
        .clk(clk),
        .reset(reset),
        .clear(q.main_rst),
        .ratio_m1(csr_m1), // R1
        .tick_in(main_cmp_tick),
        .tick_out(csr_sample_tick)
    );

    pcr_tick_div #(
        .W(2)
    ) u_ld_div (
        .clk(clk),
        .reset(reset),
        .clear(q.main_rst),
        .ratio_m1(ld_m1), // R2
        .tick_in(main_cmp_tick),
        .tick_out(main_ld_tick)
    );

    // Auxiliary path passes one for one
    pcr_tick_div #(
        .W(1)
    ) u_aux_ld (
        .clk(clk),
        .reset(reset),
        .clear(q.aux_rst),
        .ratio_m1(1'b0), // R3
        .tick_in(aux_cmp_tick),
        .tick_out(aux_ld_tick)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = ~q.aw_full;
    assign s_axi_wready = ~q.w_full;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign csr_active = (q.csr_sel != 2'h0); // R1
    assign main_counter_reset = q.main_rst;
    assign aux_counter_reset = q.aux_rst;
    assign main_pump_hiz = q.main_hiz;
    assign aux_pump_hiz = q.aux_hiz;

endmodule

`default_nettype wire

// ===== pcr_ctrl_properties.sv
// Port checks for the loop control block
`timescale 1ns/1ps
`default_nettype none

module pcr_ctrl_properties (
    input wire logic clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic s_axi_arvalid, // Read addr valid
    input wire logic s_axi_arready, // Read addr ready
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic chip_enable, // Enable pin
    input wire logic main_cmp_tick, // Main tick
    input wire logic aux_cmp_tick, // Aux tick
    input wire logic csr_sample_tick, // Reduced tick
    input wire logic main_ld_tick, // Main lock tick
    input wire logic aux_ld_tick, // Aux lock tick
    input wire logic main_counter_reset, // Main reset
    input wire logic aux_counter_reset, // Aux reset
    input wire logic main_pump_hiz, // Main float
    input wire logic aux_pump_hiz // Aux float
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_main_clr_hiz: assert property (
        main_counter_reset |-> main_pump_hiz)
        else $error("main reset without float");
    chk_aux_clr_hiz: assert property (
        aux_counter_reset |-> aux_pump_hiz)
        else $error("aux reset without float");
    chk_csr_tick_cause: assert property (
        csr_sample_tick |-> $past(main_cmp_tick))
        else $error("reduced tick without input");
    chk_ld_tick_cause: assert property (
        main_ld_tick |-> $past(main_cmp_tick))
        else $error("main lock tick without input");
    chk_aux_tick_pass: assert property (
        aux_cmp_tick && !aux_counter_reset |=>
        aux_ld_tick || aux_counter_reset)
        else $error("aux lock tick dropped");
    chk_aux_tick_cause: assert property (
        aux_ld_tick |-> $past(aux_cmp_tick))
        else $error("aux lock tick without input");
    chk_pwrup_hold: assert property (
        $rose(chip_enable) |=>
        (main_counter_reset && aux_counter_reset) [*3])
        else $error("no counter reset at power-up");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule

`default_nettype wire

// ===== pcr_host_model.sv
// Host model writing and reading words over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

module pcr_host_model (
    input wire logic clk, // Clock
    output logic [7:0] awaddr, // Write address
    output logic awvalid, // Address valid
    input wire logic awready, // Address ready
    output logic [31:0] wdata, // Write data
    output logic [3:0] wstrb, // Write strobes
    output logic wvalid, // Data valid
    input wire logic wready, // Data ready
    input wire logic bvalid, // Response valid
    input wire logic [1:0] bresp, // Write response
    output logic bready, // Response ready
    output logic [7:0] araddr, // Read address
    output logic arvalid, // Read valid
    input wire logic arready, // Read ready
    input wire logic rvalid, // Data valid
    input wire logic [31:0] rdata, // Read data
    input wire logic [1:0] rresp, // Read response
    output logic rready // Data ready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
        {araddr, arvalid, rready} <= '0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r, input logic [3:0] s = 4'hF);
        @(posedge clk);
        awaddr <= a;
        wstrb <= s;
        wdata <= {8'h00, d[23:0]};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== tb.sv
// Testbench for the loop control block
`timescale 1ns/1ps
`default_nettype none
`include "pcr_map.svh"

module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic mt = 1'b0;
    logic at = 1'b0;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdd, rdv;
    logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [1:0] bresp, rresp, resp;
    logic [3:0] ws;
    logic cst, csa, mld, ald, mrst, arst, mhiz, ahiz;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int n_c = 0;
    int n_l = 0;
    int n_a = 0;
    int c, l, a;
    // Word, levels {act,mrst,arst,mhiz,ahiz}, tick counts per 16
    logic [55:0] rows [11] = '{
        56'h00000D_00_10_10_10, 56'h40000D_10_08_10_10,
        56'h80000D_10_04_10_10, 56'hC0000D_10_01_10_10,
        56'h00001F_10_01_04_10, 56'h00008F_12_01_10_10,
        56'h00010F_11_01_10_10, 56'h00004F_1A_00_00_10,
        56'h00002F_15_01_10_00, 56'h00007D_05_10_10_00,
        56'h00000F_00_10_10_10};

    pcr_ctrl #(.PWRUP_CYCLES(3)) pcr_ctrl_i (.clk(clk), .reset(reset),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .chip_enable(ce), .main_cmp_tick(mt),
        .aux_cmp_tick(at), .csr_sample_tick(cst), .csr_active(csa),
        .main_ld_tick(mld), .aux_ld_tick(ald), .main_counter_reset(mrst),
        .aux_counter_reset(arst), .main_pump_hiz(mhiz),
        .aux_pump_hiz(ahiz));

    pcr_host_model pcr_host_model_i (.clk(clk), .awaddr(awa),
        .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
        .wvalid(wv),
        .wready(wr), .bvalid(bv), .bresp(bresp), .bready(br),
        .araddr(ara), .arvalid(arv), .arready(arr), .rvalid(rv),
        .rdata(rdd), .rresp(rresp), .rready(rr));

    always #5 clk = ~clk;

    // ****************************************
    // Tick counting and timeout
    // ****************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_c <= n_c + cst;
        n_l <= n_l + mld;
        n_a <= n_a + ald;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] lv();
        return {27'h0, csa, mrst, arst, mhiz, ahiz};
    endfunction

    // Sixteen main and aux ticks, counting each output
    task automatic pulse16();
        int c0, l0, a0;
        c0 = n_c;
        l0 = n_l;
        a0 = n_a;
        repeat (16) begin
            @(posedge clk);
            mt <= 1'b1;
            at <= 1'b1;
            @(posedge clk);
            mt <= 1'b0;
            at <= 1'b0;
        end
        settle(3);
        c = n_c - c0;
        l = n_l - l0;
        a = n_a - a0;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        check(lv() & 32'hF, 32'hF);
        settle(10);
        check(lv(), 32'h0);
        foreach (rows[i]) begin
            pcr_host_model_i.wr(`PCR_OFS_WORD, rows[i][55:32], resp);
            check(resp, `PCR_RESP_OKAY);
            settle(4);
            check(lv(), rows[i][31:24]);
            pulse16();
            check(c, rows[i][23:16]);
            check(l, rows[i][15:8]);
            check(a, rows[i][7:0]);
        end
        @(posedge clk);
        ce <= 1'b0;
        settle(5);
        @(posedge clk);
        ce <= 1'b1;
        settle(1);
        check(lv() & 32'hF, 32'hF);
        settle(10);
        check(lv(), 32'h0);
        pcr_host_model_i.wr(`PCR_OFS_CTRL, 32'h1, resp);
        settle(4);
        check(lv() & 32'hF, 32'hF);
        pcr_host_model_i.wr(`PCR_OFS_CTRL, 32'h0, resp);
        settle(10);
        check(lv(), 32'h0);
        pcr_host_model_i.wr(`PCR_OFS_STAT, 32'h3, resp);
        check(resp, `PCR_RESP_SLVERR);
        pcr_host_model_i.rd(8'h0C, rdv, resp);
        check(resp, `PCR_RESP_SLVERR);
        check(rdv, 32'h0);
        pcr_host_model_i.wr(`PCR_OFS_WORD, 32'h4F, resp, 4'h3);
        check(resp, `PCR_RESP_SLVERR);
        settle(4);
        check(lv(), 32'h0);
        pcr_host_model_i.rd(`PCR_OFS_WORD, rdv, resp);
        check(rdv, 32'h0000000F);
        pcr_host_model_i.rd(`PCR_OFS_STAT, rdv, resp);
        check(rdv, 32'h0000_0800);
        end_sim();
    end
endmodule

bind pcr_ctrl pcr_ctrl_properties pcr_ctrl_properties_i (
    .clk(clk), .reset(reset), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .chip_enable(chip_enable), .main_cmp_tick(main_cmp_tick),
    .aux_cmp_tick(aux_cmp_tick), .csr_sample_tick(csr_sample_tick),
    .main_ld_tick(main_ld_tick), .aux_ld_tick(aux_ld_tick),
    .main_counter_reset(main_counter_reset),
    .aux_counter_reset(aux_counter_reset),
    .main_pump_hiz(main_pump_hiz), .aux_pump_hiz(aux_pump_hiz));

`default_nettype wire
